// File: shared/wlv_pkg.sv
// shared constants, types and helpers of the write-leveling link
package wlv_pkg;
  localparam int LANES = 2;
  localparam int BYTE_W = 8;
  localparam int DQ_W = 16;
  localparam int MR_W = 16;
  localparam int APB_AW = 8;
  // ck is pclk divided by eight: phase 0..3 high, 4..7 low
  localparam logic [2:0] CK_HALF = 3'h4;
  localparam logic [2:0] CK_PH_LAST = 3'h7;
  localparam logic [2:0] CMD_PH = 3'h3;
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_MRS = 2'h1;
  localparam logic [1:0] MR1_SEL = 2'h1;
  localparam int A_RTT0 = 2;
  localparam int A_RTT1 = 6;
  localparam int A_WL = 7;
  localparam int A_RTT2 = 9;
  localparam int A_QOFF = 12;
  localparam logic [2:0] RTT_OFF = 3'h0;
  localparam logic [2:0] RTT_RZQ4 = 3'h1;
  localparam logic [2:0] RTT_RZQ2 = 3'h2;
  localparam logic [2:0] RTT_RZQ6 = 3'h3;
  // link timing in ck cycles; plain defaults
  localparam logic [7:0] TMOD_NCK = 8'h0C;
  localparam logic [7:0] TWLDQSEN_NCK = 8'h19;
  localparam logic [7:0] TWLMRD_NCK = 8'h28;
  localparam logic [7:0] TDQSL_NCK = 8'h01;
  localparam logic [7:0] TPRE_NCK =
    (TWLMRD_NCK > TDQSL_NCK) ? TWLMRD_NCK : TDQSL_NCK;
  localparam logic [7:0] TAOF_NCK = 8'h04;
  localparam logic [7:0] GAP_NCK = 8'h04;
  localparam logic [7:0] MAX_PULSES = 8'h40;
  // feedback delay: longest time, rounded down, at least one cycle
  localparam int CLK_NS = 25;
  localparam int TWLO_NS = 9;
  localparam int TWLO_RAW = TWLO_NS / CLK_NS;
  localparam logic [3:0] TWLO_CYC = (TWLO_RAW < 1) ? 4'h1 : 4'(TWLO_RAW);
  // margin covers both synchronisers, edge detect and output flops
  localparam logic [7:0] FB_WAIT_CYC = 8'(TWLO_CYC) + 8'h08;
  localparam logic [3:0] PULSE_LAST = 4'hF;
  localparam logic [3:0] PULSE_W = 4'h4;
  localparam logic [2:0] DLY_MAX = 3'h7;
  localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] REG_STAT = 8'h04;
  localparam logic [APB_AW-1:0] REG_DLY = 8'h08;
  localparam logic [APB_AW-1:0] REG_FB = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_QOFF = 1;
  localparam int CTRL_RTT = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_LOCK = 4;
  localparam int DLY_LANE1 = 8;

  typedef enum logic [3:0] {
    WLV_IDLE = 4'h0,
    WLV_MRS_ON = 4'h1,
    WLV_WAIT_MOD = 4'h2,
    WLV_ODT_WAIT = 4'h3,
    WLV_PRE = 4'h4,
    WLV_PULSE = 4'h5,
    WLV_FB_WAIT = 4'h6,
    WLV_STOP = 4'h7,
    WLV_ODT_OFF = 4'h8,
    WLV_EXIT = 4'h9
  } wlv_state_e;

  function automatic logic [MR_W-1:0] wlv_mr1_word(input logic wl,
      input logic qoff, input logic [2:0] rtt);
    logic [MR_W-1:0] w;
    w = '0;
    w[A_WL] = wl;
    w[A_QOFF] = qoff;
    w[A_RTT0] = rtt[0];
    w[A_RTT1] = rtt[1];
    w[A_RTT2] = rtt[2];
    return w;
  endfunction

  function automatic logic [2:0] wlv_mr1_rtt(input logic [MR_W-1:0] w);
    return {w[A_RTT2], w[A_RTT1], w[A_RTT0]};
  endfunction
endpackage

// File: shared/wlv_link_if.sv
// link between the leveling controller and the dram end
`timescale 1ns/10ps
interface wlv_link_if;
  logic ck;
  logic [1:0] cmd;
  logic [1:0] ba;
  logic [15:0] addr;
  logic odt;
  logic [1:0] strb_p;
  logic [1:0] strb_n;
  logic [1:0] strb_oe;
  logic [15:0] dq_o;
  logic [15:0] dq_oe;
  logic [1:0] strb_lvl;
  logic [15:0] dq_lvl;
  // undriven lines read low, as the terminations pull them
  assign strb_lvl = strb_p & strb_oe;
  assign dq_lvl = dq_o & dq_oe;
  modport ctl (
    output ck, cmd, ba, addr, odt, strb_p, strb_n, strb_oe,
    input dq_lvl
  );
  modport dram (
    input ck, cmd, ba, addr, odt, strb_lvl,
    output dq_o, dq_oe
  );
endinterface

// File: hdl/wlv_sync.sv
// two-flop synchroniser for inputs from another clock domain
`timescale 1ns/10ps
module wlv_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wlv_sync_s;
  wlv_sync_s r;
  wlv_sync_s next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

// File: hdl/wlv_dram.sv
// dram end: mode register, leveling terminations and clock feedback
`timescale 1ns/10ps
module wlv_dram (
  input wire logic pclk,
  input wire logic presetn,
  wlv_link_if.dram link,
  output logic wl_active,
  output logic qoff,
  output logic rtt_dqs_on,
  output logic rtt_dq_on
);
  import wlv_pkg::*;

  localparam int SW = 4 + MR_W + 2 + LANES;

  typedef struct packed {
    logic ck_d;
    logic [LANES-1:0] strb_d;
    logic [MR_W-1:0] mr1;
    logic wl_d;
    logic [7:0] tcnt;
    logic [LANES-1:0] samp;
    logic [LANES-1:0][3:0] wlo;
    logic [LANES-1:0] fb_vld;
    logic [LANES-1:0] fbv;
    logic [DQ_W-1:0] dq_o;
    logic [DQ_W-1:0] dq_oe;
    logic rtt_dqs;
    logic rtt_dq;
  } wlv_dram_s;

  wlv_dram_s r;
  wlv_dram_s next_r;
  logic [SW-1:0] sync_q;
  logic s_ck;
  logic s_odt;
  logic [1:0] s_cmd;
  logic [1:0] s_ba;
  logic [MR_W-1:0] s_addr;
  logic [LANES-1:0] s_strb;

  wlv_sync #(.W(SW)) u_sync (
    .clk(pclk),
    .rstn(presetn),
    .d({link.ck, link.odt, link.cmd, link.ba, link.addr, link.strb_lvl}),
    .q(sync_q)
  );
  assign {s_ck, s_odt, s_cmd, s_ba, s_addr, s_strb} = sync_q;

  always_comb begin
    logic ck_rise;
    logic wl;
    logic entry;
    ck_rise = s_ck & ~r.ck_d;
    wl = r.mr1[A_WL];
    entry = wl & ~r.wl_d;
    next_r = r;
    next_r.ck_d = s_ck;
    next_r.strb_d = s_strb;
    next_r.wl_d = wl;
    // commands are taken on the rising ck edge only
    if (ck_rise && s_cmd == CMD_MRS && s_ba == MR1_SEL) begin
      next_r.mr1 = s_addr;
    end
    if (wl && s_odt) begin
      if (ck_rise && r.tcnt != TWLDQSEN_NCK) begin
        next_r.tcnt = r.tcnt + 8'h01;
      end
    end else begin
      next_r.tcnt = 8'h00;
    end
    // applied one ck early so the synchroniser lag on odt and ck cannot
    // leave the strobe unterminated when the controller starts driving it
    next_r.rtt_dqs = wl & s_odt &
      (r.tcnt >= TWLDQSEN_NCK - 8'h01);
    next_r.rtt_dq = ~wl & s_odt & (wlv_mr1_rtt(r.mr1) != RTT_OFF);
    next_r.dq_o = '0;
    next_r.dq_oe = '0;
    for (int i = 0; i < LANES; i++) begin
      if (!wl || entry) begin
        // feedback is not trusted until a strobe edge arrives
        next_r.fb_vld[i] = 1'b0;
        next_r.wlo[i] = 4'h0;
      end else if (s_strb[i] && !r.strb_d[i]) begin
        next_r.samp[i] = s_ck;
        next_r.wlo[i] = TWLO_CYC;
      end else if (r.wlo[i] != 4'h0) begin
        next_r.wlo[i] = r.wlo[i] - 4'h1;
        if (r.wlo[i] == 4'h1) begin
          next_r.fbv[i] = r.samp[i];
          next_r.fb_vld[i] = 1'b1;
        end
      end
      // prime bit carries the level, the rest of the byte stays low
      next_r.dq_o[i*BYTE_W] = next_r.fbv[i];
      next_r.dq_oe[i*BYTE_W +: BYTE_W] =
        {BYTE_W{wl & ~r.mr1[A_QOFF] & next_r.fb_vld[i]}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.dq_o = r.dq_o;
  assign link.dq_oe = r.dq_oe;
  assign wl_active = r.mr1[A_WL];
  assign qoff = r.mr1[A_QOFF];
  assign rtt_dqs_on = r.rtt_dqs;
  assign rtt_dq_on = r.rtt_dq;
endmodule

// File: hdl/wlv_ctl.sv
// leveling controller end: apb registers, ck divider and strobe sweep
`timescale 1ns/10ps
module wlv_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [wlv_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  wlv_link_if.ctl link
);
  import wlv_pkg::*;

  typedef struct packed {
    logic [2:0] ph;
    logic ck;
    wlv_state_e st;
    logic [7:0] cnt;
    logic [7:0] pulses;
    logic [1:0] cmd;
    logic [1:0] ba;
    logic [MR_W-1:0] addr;
    logic odt;
    logic [LANES-1:0] strb_p;
    logic [LANES-1:0] strb_oe;
    logic qoff_cfg;
    logic [2:0] rtt_cfg;
    logic [LANES-1:0][2:0] dly;
    logic [LANES-1:0] seen0;
    logic [LANES-1:0] lock;
    logic [LANES-1:0] fb;
    logic busy;
    logic done;
    logic fail;
    logic [31:0] prdata;
    logic pslverr;
  } wlv_ctl_s;

  wlv_ctl_s r;
  wlv_ctl_s next_r;
  logic [LANES-1:0] dq_prime;
  logic [LANES-1:0] dq_s;

  function automatic logic rtt_allowed(input logic [2:0] c);
    return c == RTT_RZQ2 || c == RTT_RZQ4 || c == RTT_RZQ6;
  endfunction

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign dq_prime[g] = link.dq_lvl[g*BYTE_W];
  end

  wlv_sync #(.W(LANES)) u_dq_sync (
    .clk(pclk),
    .rstn(presetn),
    .d(dq_prime),
    .q(dq_s)
  );

  always_comb begin
    logic ck_tick;
    logic [2:0] rtt_use;
    logic [3:0] pc;
    logic [3:0] lo;
    next_r = r;
    ck_tick = (r.ph == CK_PH_LAST);
    // outputs enabled restrict termination to the safe strengths
    rtt_use = (r.qoff_cfg || rtt_allowed(r.rtt_cfg)) ?
      r.rtt_cfg : RTT_RZQ4;
    pc = r.cnt[3:0];
    lo = 4'h0;
    next_r.ph = r.ph + 3'h1;
    next_r.ck = (next_r.ph < CK_HALF);
    if (ck_tick && r.cnt != 8'h00) begin
      next_r.cnt = r.cnt - 8'h01;
    end
    // every command lasts one ck cycle, then the bus idles on nop
    if (r.ph == CMD_PH && r.cmd != CMD_NOP) begin
      next_r.cmd = CMD_NOP;
    end
    case (r.st)
      WLV_IDLE: begin
        next_r.busy = 1'b0;
      end
      WLV_MRS_ON: begin
        if (r.ph == CMD_PH) begin
          next_r.cmd = CMD_MRS;
          next_r.ba = MR1_SEL;
          // single rank: entry word sets wl, with qoff as configured and rtt from rtt_use
          next_r.addr = wlv_mr1_word(1'b1, r.qoff_cfg, rtt_use);
          next_r.cnt = TMOD_NCK;
          next_r.st = WLV_WAIT_MOD;
        end
      end
      WLV_WAIT_MOD: begin
        if (r.cnt == 8'h00) begin
          next_r.odt = 1'b1;
          next_r.cnt = TWLDQSEN_NCK;
          next_r.st = WLV_ODT_WAIT;
        end
      end
      WLV_ODT_WAIT: begin
        if (r.cnt == 8'h00) begin
          next_r.strb_p = '0;
          next_r.strb_oe = '1;
          next_r.cnt = TPRE_NCK;
          next_r.st = WLV_PRE;
        end
      end
      WLV_PRE: begin
        // pulse window starts with the rising ck edge
        if (r.cnt == 8'h00 && ck_tick) begin
          next_r.cnt = 8'h00;
          next_r.st = WLV_PULSE;
        end
      end
      WLV_PULSE: begin
        next_r.cnt = r.cnt + 8'h01;
        for (int i = 0; i < LANES; i++) begin
          lo = {1'b0, r.dly[i]};
          // one rising edge, shifted by the lane's own delay
          next_r.strb_p[i] = ~r.lock[i] && pc >= lo &&
            pc < lo + PULSE_W;
        end
        if (pc == PULSE_LAST) begin
          next_r.strb_p = '0;
          next_r.cnt = FB_WAIT_CYC;
          next_r.st = WLV_FB_WAIT;
        end
      end
      WLV_FB_WAIT: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          for (int i = 0; i < LANES; i++) begin
            if (!r.lock[i]) begin
              next_r.fb[i] = dq_s[i];
              if (r.seen0[i] && dq_s[i]) begin
                next_r.lock[i] = 1'b1;
              end else if (r.dly[i] != DLY_MAX) begin
                // step later only: a lane that starts in the high half
                // still walks on to the next rising ck edge
                next_r.dly[i] = r.dly[i] + 3'h1;
              end
              next_r.seen0[i] = ~dq_s[i];
            end
          end
          next_r.pulses = r.pulses + 8'h01;
          if (&next_r.lock) begin
            next_r.st = WLV_STOP;
          end else if (next_r.pulses == MAX_PULSES) begin
            next_r.fail = 1'b1;
            next_r.st = WLV_STOP;
          end else begin
            next_r.cnt = GAP_NCK;
            next_r.st = WLV_PRE;
          end
        end
      end
      WLV_STOP: begin
        next_r.strb_oe = '0;
        next_r.odt = 1'b0;
        next_r.cnt = TAOF_NCK;
        next_r.st = WLV_ODT_OFF;
      end
      WLV_ODT_OFF: begin
        // exit mrs only once the strobe termination is off
        if (r.cnt == 8'h00 && r.ph == CMD_PH) begin
          next_r.cmd = CMD_MRS;
          next_r.ba = MR1_SEL;
          next_r.addr = wlv_mr1_word(1'b0, r.qoff_cfg, rtt_use);
          next_r.cnt = TMOD_NCK;
          next_r.st = WLV_EXIT;
        end
      end
      WLV_EXIT: begin
        if (r.cnt == 8'h00) begin
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = WLV_IDLE;
        end
      end
      default: begin
        next_r.st = WLV_IDLE;
      end
    endcase
    // read data and error are registered in the setup cycle
    if (psel && !penable) begin
      next_r.prdata = '0;
      next_r.pslverr = 1'b0;
      case (paddr)
        REG_CTRL: begin
          next_r.prdata[CTRL_QOFF] = r.qoff_cfg;
          next_r.prdata[CTRL_RTT +: 3] = r.rtt_cfg;
        end
        REG_STAT: begin
          next_r.prdata[STAT_BUSY] = r.busy;
          next_r.prdata[STAT_DONE] = r.done;
          next_r.prdata[STAT_FAIL] = r.fail;
          next_r.prdata[STAT_LOCK +: LANES] = r.lock;
        end
        REG_DLY: begin
          next_r.prdata[2:0] = r.dly[0];
          next_r.prdata[DLY_LANE1 +: 3] = r.dly[1];
        end
        REG_FB: begin
          next_r.prdata[LANES-1:0] = r.fb;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    // configuration is frozen while a run is in progress
    if (psel && penable && pwrite && paddr == REG_CTRL && !r.busy) begin
      next_r.qoff_cfg = pwdata[CTRL_QOFF];
      next_r.rtt_cfg = pwdata[CTRL_RTT +: 3];
      if (pwdata[CTRL_START]) begin
        next_r.busy = 1'b1;
        next_r.done = 1'b0;
        next_r.fail = 1'b0;
        next_r.lock = '0;
        next_r.seen0 = '0;
        next_r.fb = '0;
        next_r.dly = '0;
        next_r.pulses = 8'h00;
        next_r.st = WLV_MRS_ON;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = r.pslverr;
  assign link.ck = r.ck;
  assign link.cmd = r.cmd;
  assign link.ba = r.ba;
  assign link.addr = r.addr;
  assign link.odt = r.odt;
  assign link.strb_p = r.strb_p;
  assign link.strb_n = ~r.strb_p;
  assign link.strb_oe = r.strb_oe;
endmodule

// File: bench/wlv_link_monitor.sv
// concurrent checks on the leveling link between the two ends
`timescale 1ns/10ps
module wlv_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck,
  input wire logic [1:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [15:0] addr,
  input wire logic odt,
  input wire logic [1:0] strb_p,
  input wire logic [1:0] strb_n,
  input wire logic [1:0] strb_oe,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  input wire logic [1:0] strb_lvl,
  input wire logic [15:0] dq_lvl
);
  import wlv_pkg::*;
  // margins of two ck cycles on tmod and one on the termination delay allow for
  // where within the held command the controller starts its count
  localparam int MOD_MIN = int'(TMOD_NCK) * 8 - 16;
  localparam int EN_MIN = int'(TWLDQSEN_NCK) * 8 - 8;
  logic wl;
  logic qo;
  logic [4:0] warm;
  logic [15:0] odt_cnt;
  logic [15:0] mrs_cnt;
  logic [1:0] ck_cap;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wl <= 1'b0;
      qo <= 1'b0;
      warm <= 5'h0;
      odt_cnt <= 16'h0;
      mrs_cnt <= 16'h0;
      ck_cap <= 2'h0;
    end else begin
      if (cmd == CMD_MRS && ba == MR1_SEL) begin
        wl <= addr[A_WL];
        qo <= addr[A_QOFF];
      end
      // first ck phase after reset is short, so wait before timing it
      warm <= warm[4] ? warm : warm + 5'h1;
      odt_cnt <= !odt ? 16'h0 : (&odt_cnt ? odt_cnt : odt_cnt + 16'h1);
      mrs_cnt <= (cmd == CMD_MRS) ? 16'h0 :
        (&mrs_cnt ? mrs_cnt : mrs_cnt + 16'h1);
      if ($rose(strb_lvl[0])) ck_cap[0] <= ck;
      if ($rose(strb_lvl[1])) ck_cap[1] <= ck;
    end
  end
  a_ck_divide: assert property (
    warm[4] && $rose(ck) |-> ck[*4] ##1 !ck[*4] ##1 ck)
    else $error("link clock is not pclk divided by eight");
  a_mrs_hold: assert property (
    $rose(cmd == CMD_MRS) |-> (cmd == CMD_MRS)[*8] ##1 cmd == CMD_NOP)
    else $error("mode register command not held one ck cycle");
  a_nop_only_leveling: assert property (
    cmd == CMD_MRS && $past(cmd) == CMD_NOP && wl |-> !addr[A_WL])
    else $error("command other than exit issued while leveling");
  a_odt_after_mod: assert property (
    $rose(odt) |-> mrs_cnt >= MOD_MIN)
    else $error("odt raised before tmod after entry");
  a_dqs_after_term: assert property (
    $rose(strb_oe[0]) || $rose(strb_oe[1]) |-> odt_cnt >= EN_MIN)
    else $error("strobe driven before termination delay");
  a_strobe_needs_odt: assert property (
    |strb_oe |-> odt)
    else $error("strobe driven while odt low");
  a_strobe_pair: assert property (
    $rose(strb_oe[0]) |-> !strb_p[0] && strb_n[0])
    else $error("strobe pair not starting low when first driven");
  a_pulse_width: assert property (
    $rose(strb_p[0]) |-> strb_p[0][*4] ##1 !strb_p[0])
    else $error("lower strobe pulse width wrong");
  a_fb_lower_lane: assert property (
    !qo && $rose(strb_lvl[0]) |-> ##[2:10] (dq_oe[0] && dq_o[0] == ck_cap[0]))
    else $error("lower lane feedback missing or wrong");
  a_fb_upper_lane: assert property (
    !qo && $rose(strb_lvl[1]) |-> ##[2:10] (dq_oe[8] && dq_o[8] == ck_cap[1]))
    else $error("upper lane feedback missing or wrong");
  a_dq_drive_leveling: assert property (
    $rose(|dq_oe) |-> wl)
    else $error("dq driven outside leveling");
  a_nonprime_low: assert property (
    dq_lvl[15:9] == 7'h0 && dq_lvl[7:1] == 7'h0)
    else $error("non-prime dq not low");
endmodule

// File: bench/dram_write_leveling_test.sv
// self-checking bench: apb-driven leveling runs across the joined link
`timescale 1ns/10ps
module dram_write_leveling_test;
  import wlv_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wl_active;
  logic qoff;
  logic rtt_dqs_on;
  logic rtt_dq_on;
  logic saw_wl, saw_dqs, bad_dq, saw_dq, saw_q;
  logic bad_dqs;
  logic [MR_W-1:0] entry_word = '0;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks_done = 0;
  wlv_link_if link();
  wlv_ctl i_wlv_ctl(.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctl));
  wlv_dram i_wlv_dram(.pclk(pclk), .presetn(presetn), .link(link.dram),
    .wl_active(wl_active), .qoff(qoff), .rtt_dqs_on(rtt_dqs_on),
    .rtt_dq_on(rtt_dq_on));
  wlv_link_monitor i_wlv_link_monitor(.pclk(pclk), .presetn(presetn),
    .ck(link.ck), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
    .odt(link.odt), .strb_p(link.strb_p), .strb_n(link.strb_n),
    .strb_oe(link.strb_oe), .dq_o(link.dq_o), .dq_oe(link.dq_oe),
    .strb_lvl(link.strb_lvl), .dq_lvl(link.dq_lvl));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (wl_active) saw_wl <= 1'b1;
    if (rtt_dqs_on) saw_dqs <= 1'b1;
    if (rtt_dq_on && wl_active) bad_dq <= 1'b1;
    if (|link.strb_oe && !rtt_dqs_on) bad_dqs <= 1'b1;
    if (|link.dq_oe) saw_dq <= 1'b1;
    if (qoff) saw_q <= 1'b1;
    if (link.cmd == CMD_MRS && link.addr[A_WL]) entry_word <= link.addr;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic level(input logic q, input logic [2:0] code,
      input logic [2:0] exp_rtt, input logic exp_fail);
    int n;
    saw_wl <= 1'b0;
    saw_dqs <= 1'b0;
    bad_dq <= 1'b0;
    bad_dqs <= 1'b0;
    saw_dq <= 1'b0;
    saw_q <= 1'b0;
    apb(1'b1, REG_CTRL, (32'(code) << CTRL_RTT) | (32'(q) << CTRL_QOFF) | 1);
    // a second order while busy must not disturb the run
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd & 32'h72, (32'(code) << CTRL_RTT) | (32'(q) << CTRL_QOFF));
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[STAT_DONE] !== 1'b1 && n < 3000);
    check(rd & 32'h37, exp_fail ? 32'h06 : 32'h32);
    check({entry_word[A_RTT2], entry_word[A_RTT1], entry_word[A_RTT0]},
      exp_rtt);
    check(entry_word[A_QOFF], q);
    check(saw_wl, 1'b1);
    check(wl_active, 1'b0);
    check(saw_q, q);
    check(saw_dq, !q);
    check(saw_dqs, 1'b1);
    check(bad_dq, 1'b0);
    check(bad_dqs, 1'b0);
    apb(1'b0, REG_FB, 32'h0);
    check(rd[1:0], exp_fail ? 2'h0 : 2'h3);
    if (exp_fail) begin
      apb(1'b0, REG_DLY, 32'h0);
      check(rd & 32'h707, 32'h707);
    end
    $display("leveling run qoff %0d code %0d finished", q, code);
  endtask
  initial begin
    #1500000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd & 32'h72, 32'h0);
    $display("register reset test finished");
    for (int c = 0; c < 8; c++) begin
      level(1'b0, 3'(c), (c >= 1 && c <= 3) ? 3'(c) : RTT_RZQ4, 1'b0);
    end
    level(1'b1, 3'h5, 3'h5, 1'b1);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (300) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({link.odt, link.strb_oe, link.dq_oe}, 19'h0);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd, 32'h0);
    level(1'b0, RTT_RZQ6, RTT_RZQ6, 1'b0);
    $display("mid-run reset test finished");
    tally_and_finish();
  end
endmodule
